/* File: core/spmsp_pkg.sv */
// Constants and carrier types for the speed monitor and shared port block.
package spmsp_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned SEL_W = 4;
  localparam int unsigned BUF_W = 24;
  localparam int unsigned AXIS_W = 2;
  localparam int unsigned PIN_N = 6;
  localparam int unsigned SPEED_W = 16;
  localparam int unsigned SPEED_LSB = 8;

  // ----------------------------------------------------------------
  // Register select codes
  // ----------------------------------------------------------------
  localparam logic [SEL_W-1:0] SEL_SPEED = 4'h6;
  localparam logic [SEL_W-1:0] SEL_LEVEL = 4'hb;
  localparam logic [SEL_W-1:0] SEL_DIR = 4'hc;

  // ----------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------
  localparam logic [SPEED_W-1:0] SPEED_MAX = 16'h1fff;
  localparam logic [SPEED_W-1:0] SPEED_IDLE = 16'h0000;
  localparam logic [PIN_N-1:0] LEVEL_RST = 6'h00;
  localparam logic [PIN_N-1:0] DIR_RST = 6'h3f;
  localparam logic [BUF_W-1:0] RDBUF_RST = 24'h000000;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [SEL_W-1:0] sel;
    logic wr;
    logic rd;
    logic [AXIS_W-1:0] axis;
    logic [BUF_W-1:0] wdata;
  } spmsp_req_type;

  typedef struct packed {
    logic [PIN_N-1:0] level;
    logic [PIN_N-1:0] oe;
  } spmsp_pin_type;

endpackage : spmsp_pkg

/* File: core/spmsp_speed_mon.sv */
// Registered current speed value, clamped to range and zero while idle.
`timescale 1ns/1ps
module spmsp_speed_mon (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic busy_i,
  input wire logic [spmsp_pkg::SPEED_W-1:0] step_i,
  output logic [spmsp_pkg::SPEED_W-1:0] speed_o
);
  import spmsp_pkg::*;

  logic [SPEED_W-1:0] speed_d;
  logic [SPEED_W-1:0] speed_q;

  // ----------------------------------------------------------------
  // Next value
  // ----------------------------------------------------------------
  always_comb begin
    if (!busy_i) begin
      speed_d = SPEED_IDLE; // R04
    end else if (step_i > SPEED_MAX) begin
      speed_d = SPEED_MAX; // R03
    end else begin
      speed_d = step_i; // R02 R05
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      speed_q <= SPEED_IDLE;
    end else begin
      speed_q <= speed_d;
    end
  end

  assign speed_o = speed_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  a_speed_idle_zero: assert property (!busy_i |=> speed_o == SPEED_IDLE) // R04
    else $error("speed not zero after idle");
  a_speed_in_range: assert property (busy_i && step_i > SPEED_MAX |=> speed_o == SPEED_MAX) // R03
    else $error("speed not clamped to range");
  a_speed_tracks_step: assert property (busy_i && step_i <= SPEED_MAX |=> speed_o == $past(step_i)) // R05
    else $error("speed does not follow generator step");

  c_speed_running: cover property (busy_i ##1 busy_i && speed_o != SPEED_IDLE);

endmodule : spmsp_speed_mon

/* File: core/spmsp_top.sv */
// Current speed read-back and six-pin shared port with direction control.
`timescale 1ns/1ps
// Overview of operation
// R01: Speed read-only, code 0110b, bits 23..8.
// R02: Speed uses low/high setting step units.
// R03: Speed lies between zero and 8191.
// R04: Speed reads zero while no pulses run.
// R05: Speed equals pulse rate over magnification.
// R06: Level register code 1011b, bits 7..6 zero.
// R07: Level write drives pin, read returns pin.
// R08: Shared-port registers exist only with serial host.
// R09: Parallel host: writes ignored, reads return 00h.
// R10: One level register, axis selection ignored.
// R11: One direction register, axis selection ignored.
// R12: Direction register code 1100b, bits 7..6 zero.
// R13: Direction 0 drives output, 1 is input.
// R14: Input releases driver, keeps level bit.
module spmsp_top (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic serial_host_i,
  input wire spmsp_pkg::spmsp_req_type req_i,
  output logic [spmsp_pkg::BUF_W-1:0] read_buf_o,
  input wire logic pulse_busy_i,
  input wire logic [spmsp_pkg::SPEED_W-1:0] speed_step_i,
  input wire logic [spmsp_pkg::PIN_N-1:0] shared_pins_i,
  output spmsp_pkg::spmsp_pin_type shared_pins_o
);
  import spmsp_pkg::*;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic logic sel_hit(input logic [SEL_W-1:0] sel, input logic [SEL_W-1:0] code);
    sel_hit = (sel == code);
  endfunction : sel_hit

  logic [SPEED_W-1:0] speed;
  logic [PIN_N-1:0] level_d;
  logic [PIN_N-1:0] level_q;
  logic [PIN_N-1:0] dir_d;
  logic [PIN_N-1:0] dir_q;
  logic [BUF_W-1:0] rdbuf_d;
  logic [BUF_W-1:0] rdbuf_q;
  logic port_wr;

  // ----------------------------------------------------------------
  // Speed monitor
  // ----------------------------------------------------------------
  spmsp_speed_mon u_speed (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .busy_i(pulse_busy_i),
    .step_i(speed_step_i),
    .speed_o(speed)
  );

  // ----------------------------------------------------------------
  // Shared port registers
  // ----------------------------------------------------------------
  // The axis field is never looked at, so every axis reaches the same pair.
  assign port_wr = req_i.wr && serial_host_i; // R08 R09 R10 R11

  always_comb begin
    level_d = level_q;
    dir_d = dir_q;
    if (port_wr && sel_hit(req_i.sel, SEL_LEVEL)) begin
      level_d = req_i.wdata[PIN_N-1:0]; // R07 R10
    end
    if (port_wr && sel_hit(req_i.sel, SEL_DIR)) begin
      dir_d = req_i.wdata[PIN_N-1:0]; // R11 R13
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      level_q <= LEVEL_RST;
      dir_q <= DIR_RST;
    end else begin
      level_q <= level_d;
      dir_q <= dir_d;
    end
  end

  // Level bits are held while a pin is an input and reappear when it drives again.
  assign shared_pins_o.level = level_q; // R14
  assign shared_pins_o.oe = ~dir_q; // R13 R14

  // ----------------------------------------------------------------
  // Read buffer
  // ----------------------------------------------------------------
  always_comb begin
    rdbuf_d = rdbuf_q;
    if (req_i.rd) begin
      rdbuf_d = RDBUF_RST;
      if (sel_hit(req_i.sel, SEL_SPEED)) begin
        rdbuf_d[SPEED_LSB +: SPEED_W] = speed; // R01
      end else if (sel_hit(req_i.sel, SEL_LEVEL) && serial_host_i) begin
        rdbuf_d[PIN_N-1:0] = shared_pins_i; // R06 R07
      end else if (sel_hit(req_i.sel, SEL_DIR) && serial_host_i) begin
        rdbuf_d[PIN_N-1:0] = dir_q; // R12
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdbuf_q <= RDBUF_RST;
    end else begin
      rdbuf_q <= rdbuf_d;
    end
  end

  assign read_buf_o = rdbuf_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  a_speed_read_back: assert property (req_i.rd && sel_hit(req_i.sel, SEL_SPEED) |=> // R01
    read_buf_o == {$past(speed), 8'h00})
    else $error("speed read-back misplaced");
  a_speed_idle_read: assert property (!pulse_busy_i ##1 !pulse_busy_i && req_i.rd && // R04
    sel_hit(req_i.sel, SEL_SPEED) |=> read_buf_o == RDBUF_RST)
    else $error("speed read not zero while idle");
  a_level_read_pins: assert property (req_i.rd && serial_host_i && // R06
    sel_hit(req_i.sel, SEL_LEVEL) |=> read_buf_o == {18'h0, $past(shared_pins_i)})
    else $error("level read does not show pins");
  a_level_write_pin: assert property (port_wr && sel_hit(req_i.sel, SEL_LEVEL) |=> // R07
    shared_pins_o.level == $past(req_i.wdata[PIN_N-1:0]))
    else $error("level write not driven");
  a_parallel_no_write: assert property (req_i.wr && !serial_host_i |=> // R09
    $stable(level_q) && $stable(dir_q))
    else $error("parallel write changed port");
  a_parallel_read_zero: assert property (req_i.rd && !serial_host_i && // R09
    (sel_hit(req_i.sel, SEL_LEVEL) || sel_hit(req_i.sel, SEL_DIR)) |=> read_buf_o == RDBUF_RST)
    else $error("parallel read not zero");
  a_dir_read_back: assert property (req_i.rd && serial_host_i && // R12
    sel_hit(req_i.sel, SEL_DIR) |=> read_buf_o == {18'h0, $past(dir_q)})
    else $error("direction read wrong");
  a_dir_sets_driver: assert property (port_wr && sel_hit(req_i.sel, SEL_DIR) |=> // R13
    shared_pins_o.oe == ~$past(req_i.wdata[PIN_N-1:0]))
    else $error("driver enable does not follow direction");
  a_dir_keeps_level: assert property (port_wr && sel_hit(req_i.sel, SEL_DIR) |=> // R14
    $stable(level_q))
    else $error("direction write disturbed level");
  a_axis_ignored: assert property (port_wr && sel_hit(req_i.sel, SEL_LEVEL) && // R10
    req_i.axis != 2'h0 |=> level_q == $past(req_i.wdata[PIN_N-1:0]))
    else $error("axis selection blocked level write");
  a_axis_dir_ignored: assert property (port_wr && sel_hit(req_i.sel, SEL_DIR) && // R11
    req_i.axis != 2'h0 |=> dir_q == $past(req_i.wdata[PIN_N-1:0]))
    else $error("axis selection blocked direction write");

  // ----------------------------------------------------------------
  // Read buffer placement and width
  // ----------------------------------------------------------------
  // Reset leaves every pin released so nothing is driven before the host sets a direction.
  a_reset_port_state: assert property ($rose(reset_n_i) |-> level_q == LEVEL_RST && // R13
    dir_q == DIR_RST && read_buf_o == RDBUF_RST)
    else $error("port state wrong after reset");
  a_speed_low_zero: assert property (req_i.rd && sel_hit(req_i.sel, SEL_SPEED) |=> // R01
    read_buf_o[SPEED_LSB-1:0] == 8'h00)
    else $error("speed read low byte not zero");
  a_speed_no_write: assert property (req_i.wr && sel_hit(req_i.sel, SEL_SPEED) |=> // R01
    $stable(level_q) && $stable(dir_q))
    else $error("speed write changed port");
  a_read_buf_holds: assert property (!req_i.rd |=> $stable(read_buf_o)) // R01
    else $error("read buffer changed without read");
  a_speed_read_range: assert property (req_i.rd && sel_hit(req_i.sel, SEL_SPEED) |=> // R03
    read_buf_o[SPEED_LSB +: SPEED_W] <= SPEED_MAX)
    else $error("speed read beyond range");
  a_level_top_zero: assert property (req_i.rd && sel_hit(req_i.sel, SEL_LEVEL) |=> // R06
    read_buf_o[BUF_W-1:PIN_N] == 18'h0)
    else $error("level read upper bits not zero");
  a_dir_top_zero: assert property (req_i.rd && sel_hit(req_i.sel, SEL_DIR) |=> // R12
    read_buf_o[BUF_W-1:PIN_N] == 18'h0)
    else $error("direction read upper bits not zero");

  // ----------------------------------------------------------------
  // Host interface and axis selection
  // ----------------------------------------------------------------
  // Except a_level_keeps_dir, these look at the host inputs rather than the internal write enable, so a bad enable shows.
  a_serial_level_write: assert property (req_i.wr && serial_host_i && // R08
    sel_hit(req_i.sel, SEL_LEVEL) |=> level_q == $past(req_i.wdata[PIN_N-1:0]))
    else $error("serial level write lost");
  a_serial_dir_write: assert property (req_i.wr && serial_host_i && // R08
    sel_hit(req_i.sel, SEL_DIR) |=> dir_q == $past(req_i.wdata[PIN_N-1:0]))
    else $error("serial direction write lost");
  a_axis_level_read: assert property (req_i.rd && serial_host_i && // R10
    sel_hit(req_i.sel, SEL_LEVEL) && req_i.axis != 2'h0 |=>
    read_buf_o == {18'h0, $past(shared_pins_i)})
    else $error("axis selection changed level read");
  a_axis_dir_read: assert property (req_i.rd && serial_host_i && // R11
    sel_hit(req_i.sel, SEL_DIR) && req_i.axis != 2'h0 |=>
    read_buf_o == {18'h0, $past(dir_q)})
    else $error("axis selection changed direction read");
  a_level_keeps_dir: assert property (port_wr && sel_hit(req_i.sel, SEL_LEVEL) |=> // R13
    $stable(dir_q))
    else $error("level write disturbed direction");

  // ----------------------------------------------------------------
  // Per-pin driver checks
  // ----------------------------------------------------------------
  // A released pin keeps its level bit, so a later switch back to output drives it at once.
  for (genvar n = 0; n < PIN_N; n++) begin : g_pin_check
    a_pin_released: assert property (port_wr && sel_hit(req_i.sel, SEL_DIR) && // R13
      req_i.wdata[n] |=> !shared_pins_o.oe[n])
      else $error("input pin still driven");
    a_pin_level_held: assert property (!shared_pins_o.oe[n] && // R14
      !(port_wr && sel_hit(req_i.sel, SEL_LEVEL)) |=> $stable(shared_pins_o.level[n]))
      else $error("released pin lost its level");
  end : g_pin_check

  // ----------------------------------------------------------------
  // Coverage
  // ----------------------------------------------------------------
  c_speed_read: cover property (pulse_busy_i && req_i.rd && sel_hit(req_i.sel, SEL_SPEED));
  c_pin_output: cover property (port_wr && sel_hit(req_i.sel, SEL_DIR) ##1
    port_wr && sel_hit(req_i.sel, SEL_LEVEL));
  c_parallel_read: cover property (req_i.rd && !serial_host_i && sel_hit(req_i.sel, SEL_LEVEL));
  c_all_released: cover property (port_wr && sel_hit(req_i.sel, SEL_DIR) &&
    req_i.wdata[PIN_N-1:0] == 6'h3f);

endmodule : spmsp_top

/* File: testbench/spmsp_pin_model.sv */
// Wire model of the six shared pins, with an outside driver on released pins.
`timescale 1ns/1ps
module spmsp_pin_model (
  input wire spmsp_pkg::spmsp_pin_type pins_i,
  input wire logic [spmsp_pkg::PIN_N-1:0] ext_i,
  output logic [spmsp_pkg::PIN_N-1:0] wire_o
);
  import spmsp_pkg::*;
  // A pin the device releases shows the outside level, a driven pin the device level.
  always_comb begin
    for (int n = 0; n < PIN_N; n++) begin
      wire_o[n] = pins_i.oe[n] ? pins_i.level[n] : ext_i[n];
    end
  end
endmodule : spmsp_pin_model

/* File: testbench/spmsp_top_tb_top.sv */
// Self-checking bench for the speed read-back and shared port block.
`timescale 1ns/1ps
module spmsp_top_tb_top;
  import spmsp_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic serial_host_i = 1'b1;
  spmsp_req_type req_i = '0;
  logic [BUF_W-1:0] read_buf_o;
  logic pulse_busy_i = 1'b0;
  logic [SPEED_W-1:0] speed_step_i = 16'h0000;
  logic [PIN_N-1:0] ext_pins = 6'h2a;
  logic [PIN_N-1:0] pin_wire;
  spmsp_pin_type shared_pins_o;
  int error_cnt = 0;
  int check_count = 0;

  always #4 clk_i = ~clk_i;

  spmsp_top i_dut (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .serial_host_i(serial_host_i),
    .req_i(req_i),
    .read_buf_o(read_buf_o),
    .pulse_busy_i(pulse_busy_i),
    .speed_step_i(speed_step_i),
    .shared_pins_i(pin_wire),
    .shared_pins_o(shared_pins_o)
  );

  spmsp_pin_model i_pins (
    .pins_i(shared_pins_o),
    .ext_i(ext_pins),
    .wire_o(pin_wire)
  );

  task automatic check(input string name, input logic [23:0] exp, input logic [23:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // One request, driven just after an edge, dropped after the edge that takes it, then one
  // idle edge so that the next request never rewrites the strobe in the step that drops it.
  task automatic access(input logic wr, input logic [3:0] sel, input logic [1:0] axis,
                        input logic [23:0] data);
    req_i = '{sel: sel, wr: wr, rd: ~wr, axis: axis, wdata: data};
    @(posedge clk_i);
    #1;
    req_i = '0;
    @(posedge clk_i);
    #1;
  endtask : access

  task automatic test_reset();
    check("rdbuf", 24'h000000, read_buf_o);
    check("pins", 24'h000000, {12'h000, shared_pins_o});
    access(1'b0, SEL_DIR, 2'h0, 24'h0);
    check("dir", 24'h00003f, read_buf_o);
  endtask : test_reset

  task automatic test_port();
    access(1'b1, SEL_DIR, 2'h0, 24'hffff30);
    access(1'b1, SEL_LEVEL, 2'h3, 24'hffff15);
    check("pins", 24'h00054f, {12'h000, shared_pins_o});
    access(1'b0, SEL_LEVEL, 2'h2, 24'h0);
    check("level", 24'h000025, read_buf_o);
    access(1'b0, SEL_DIR, 2'h1, 24'h0);
    check("dir", 24'h000030, read_buf_o);
    access(1'b1, SEL_DIR, 2'h2, 24'h00003f);
    check("pins", 24'h000540, {12'h000, shared_pins_o});
    access(1'b1, SEL_DIR, 2'h1, 24'h000000);
    check("pins", 24'h00057f, {12'h000, shared_pins_o});
    access(1'b0, SEL_LEVEL, 2'h0, 24'h0);
    check("level", 24'h000015, read_buf_o);
  endtask : test_port

  task automatic test_parallel();
    serial_host_i = 1'b0;
    access(1'b1, SEL_LEVEL, 2'h0, 24'h00002a);
    access(1'b1, SEL_DIR, 2'h0, 24'h00003f);
    check("pins", 24'h00057f, {12'h000, shared_pins_o});
    access(1'b0, SEL_LEVEL, 2'h0, 24'h0);
    check("level", 24'h000000, read_buf_o);
    access(1'b0, SEL_DIR, 2'h0, 24'h0);
    check("dir", 24'h000000, read_buf_o);
    serial_host_i = 1'b1;
  endtask : test_parallel

  task automatic test_speed();
    logic busy_tab [4] = '{1'b0, 1'b1, 1'b1, 1'b1};
    logic [15:0] step_tab [4] = '{16'h1234, 16'h1234, 16'hffff, 16'h1fff};
    logic [23:0] exp_tab [4] = '{24'h000000, 24'h123400, 24'h1fff00, 24'h1fff00};
    for (int k = 0; k < 4; k++) begin
      pulse_busy_i = busy_tab[k];
      speed_step_i = step_tab[k];
      access(1'b1, SEL_SPEED, 2'h0, 24'h000000);
      access(1'b0, SEL_SPEED, 2'h0, 24'h0);
      check("speed", exp_tab[k], read_buf_o);
    end
    check("pins", 24'h00057f, {12'h000, shared_pins_o});
    pulse_busy_i = 1'b0;
    @(posedge clk_i);
    #1;
    access(1'b0, SEL_SPEED, 2'h0, 24'h0);
    check("speed", 24'h000000, read_buf_o);
  endtask : test_speed

  task automatic finish_test();
    if (error_cnt == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  initial begin
    #100000;
    error_cnt++;
    finish_test();
  end

  initial begin
    repeat (8) @(posedge clk_i);
    #1;
    reset_n_i = 1'b1;
    test_reset();
    test_port();
    test_parallel();
    test_speed();
    finish_test();
  end
endmodule : spmsp_top_tb_top
